// file: rtl/debug_pin_sync.sv
`timescale 1ns/10ps
`default_nettype none

// Brings the debug pin into the core clock domain and flags falling edges
module debug_pin_sync #(
   parameter int STAGES = 2
) (
   input wire logic i_sys_clk,
   input wire logic i_srst,
   input wire logic i_pin,
   output logic o_pin_level,
   output logic o_pin_fall
);

   logic [STAGES-1:0] sync_r; // Synchroniser chain, bit 0 is the first stage
   logic level_prev_r; // Last synchronised level, for edge detection

   // Chain shifts in the raw pin; only the last stage is looked at
   always_ff @(posedge i_sys_clk) begin
      if (i_srst) begin
         sync_r <= {STAGES{1'b1}};
         level_prev_r <= 1'b1;
      end else begin
         sync_r <= {sync_r[STAGES-2:0], i_pin};
         level_prev_r <= sync_r[STAGES-1];
      end
   end

   // Pin idles high, so reset values avoid a false edge
   assign o_pin_level = sync_r[STAGES-1];
   assign o_pin_fall = level_prev_r & ~sync_r[STAGES-1];

endmodule

`default_nettype wire

// file: rtl/debug_status_ack_logic.sv
// Function
// R1 - Flag 3:1 setting command acks long
// R2 - Later correct commands ack normal
// R3 - Later failing commands ack long
// R4 - First ack after wait/stop long
// R5 - Host edge on pending ack: overrun, no long
// R6 - After next byte, overrun forces long acks
// R7 - Unimplemented opcode flags, no long ack
// R8 - Other illegal command causes long ack
// R9 - Register reached only by debug commands
// R10 - Bits 7:5,3:0 clear by writing one
// R11 - Bit four cleared only by sync
// R12 - Wait flag set, clear after exit
// R13 - Stop flag set on request, enabled
// R14 - Stop flag clear ignored during stop
// R15 - RAM ECC double fault flag
// R16 - Host reads status after long ack
`include "debug_status_defines.svh"
`timescale 1ns/10ps
`default_nettype none

module debug_status_ack_logic
   import debug_status_pkg::*;
#(
   parameter int SYNC_STAGES = `DSL_SYNC_STAGES
) (
   input wire logic i_sys_clk,
   input wire logic i_srst,
   input wire logic i_debug_pin,
   input wire logic i_bdc_enable,
   input wire logic i_ack_enable,
   input wire logic i_wait_mode,
   input wire logic i_stop_mode,
   input wire logic i_stop_request,
   input wire logic i_ram_dbl_fault,
   input wire logic i_ack_pending,
   input wire logic i_byte_received,
   input wire logic i_sync_pulse,
   input wire logic i_cmd_done,
   input wire logic i_cmd_uses_ack,
   input wire logic i_cmd_ok,
   input wire logic i_cmd_unimplemented,
   input wire logic i_cmd_illegal_other,
   input wire logic i_no_response,
   input wire logic i_illegal_access,
   input wire logic i_cmd_error,
   input wire logic i_status_wr,
   input wire logic [`DSL_WIDTH-1:0] i_status_wdata,
   output logic [`DSL_WIDTH-1:0] o_status_low,
   output logic o_ack_strobe,
   output logic o_ack_long
);

   // Synchronised pin edge
   logic pin_fall; // One-cycle pulse on a host falling edge

   // Status register and its next value
   logic [`DSL_WIDTH-1:0] status_r; // Debug status low register
   logic [`DSL_WIDTH-1:0] status_nxt; // Value for the next edge
   logic [`DSL_WIDTH-1:0] set_vec; // Hardware set requests per bit
   logic [`DSL_WIDTH-1:0] clr_vec; // Clear requests per bit
   logic [`DSL_WIDTH-1:0] wr_ones; // Written ones, zero when no write

   // Individual set conditions
   logic set_wait; // Device is in wait mode
   logic set_stop; // Stop instruction while debug controller enabled
   logic set_ram; // Debug RAM write hit a double fault
   logic set_overrun; // Host edge while our ack still pending
   logic set_illegal_cmd; // Any illegal command cause

   // Long acknowledge decision terms
   logic ack_issue; // Command finished and wants an ack
   logic cause_31; // Command set a flag in 3:1 in a way that may go long
   logic cmd_failed; // Command did not execute correctly, unimplemented opcode excluded
   logic ws_now; // Wait or stop flag currently set
   logic ws_prev_r; // Same, one cycle earlier
   logic ws_rise; // Wait or stop flag just became set
   logic ws_pend_r; // First ack after wait/stop still owed as long
   logic ws_pend_nxt; // Next value of the owed flag
   logic ws_first; // This ack is the first since wait/stop
   logic ovr_force; // Overrun seen and a byte followed
   logic ovr_hold_off; // Overrun too fresh to go long
   logic long_nxt; // Ack length for the current command

   // Overrun tracking
   overrun_state_t ovr_state_r; // Where we are after an overrun
   overrun_state_t ovr_state_nxt; // Next overrun state

   // Pin comes from another domain, so it is synchronised first
   debug_pin_sync #(
      .STAGES(SYNC_STAGES)
   ) u_pin_sync (
      .i_sys_clk(i_sys_clk),
      .i_srst(i_srst),
      .i_pin(i_debug_pin),
      .o_pin_level(),
      .o_pin_fall(pin_fall)
   );

   // Write port is the debug command path only, no processor address
   assign wr_ones = i_status_wr ? i_status_wdata : `DSL_WIDTH'(0); // R9

   // Set sources
   assign set_wait = i_wait_mode; // R12
   assign set_stop = i_stop_request & i_bdc_enable; // R13
   assign set_ram = i_ram_dbl_fault; // R15
   assign set_overrun = pin_fall & i_ack_pending; // R5
   assign set_illegal_cmd = i_cmd_unimplemented | i_cmd_illegal_other;

   // Gather set requests into bit positions
   always_comb begin
      set_vec = `DSL_WIDTH'(0);
      set_vec[`DSL_WAIT_BIT] = set_wait;
      set_vec[`DSL_STOP_BIT] = set_stop;
      set_vec[`DSL_RAM_FAULT_BIT] = set_ram;
      set_vec[`DSL_OVERRUN_BIT] = set_overrun;
      set_vec[`DSL_NO_RESPONSE_BIT] = i_no_response;
      set_vec[`DSL_ILLEGAL_ACCESS_BIT] = i_illegal_access;
      set_vec[`DSL_ILLEGAL_COMMAND_BIT] = set_illegal_cmd;
      set_vec[`DSL_COMMAND_ERROR_BIT] = i_cmd_error;
   end

   // Gather clear requests; writing zero never clears anything
   always_comb begin
      clr_vec = wr_ones; // R10
      // Wait flag only clears once wait mode has ended
      clr_vec[`DSL_WAIT_BIT] = wr_ones[`DSL_WAIT_BIT] & ~i_wait_mode; // R12
      // Stop flag write is ignored while still stopped
      clr_vec[`DSL_STOP_BIT] = wr_ones[`DSL_STOP_BIT] & ~i_stop_mode; // R14
      // Overrun ignores writes, only a sync pulse clears it
      clr_vec[`DSL_OVERRUN_BIT] = i_sync_pulse; // R11
   end

   // Set beats clear so an event in the clearing cycle survives
   assign status_nxt = set_vec | (status_r & ~clr_vec); // R10

   // Ack is wanted only with handshaking on and an ack-type command
   assign ack_issue = i_cmd_done & i_cmd_uses_ack & i_ack_enable;

   // Flags 3:1 set by this command; unimplemented opcode excluded
   assign cause_31 = i_no_response | i_illegal_access | i_cmd_illegal_other; // R1 R8 R7

   // A failing command goes long, except the unimplemented opcode case
   assign cmd_failed = ~i_cmd_ok & ~i_cmd_unimplemented; // R3 R7

   // Wait/stop rise detection on the stored flags
   assign ws_now = status_r[`DSL_WAIT_BIT] | status_r[`DSL_STOP_BIT];
   assign ws_rise = ws_now & ~ws_prev_r;
   assign ws_first = ws_pend_r | ws_rise; // R4

   // Owed long ack is consumed by the next ack, later ones are normal
   assign ws_pend_nxt = ack_issue ? 1'b0 : (ws_pend_r | ws_rise); // R4

   // Overrun phases
   assign ovr_force = (ovr_state_r == OVR_FORCE); // R6
   // Long pulse would collide with the host's new transmission
   assign ovr_hold_off = (ovr_state_r == OVR_WAIT_BYTE) | set_overrun; // R5

   // Ack length; correct commands with no owed cause stay normal
   assign long_nxt = (cause_31 | cmd_failed | ws_first | ovr_force) & ~ovr_hold_off; // R1 R2 R3 R6

   // Overrun tracking: fresh overrun waits a byte, then forces long acks
   always_comb begin
      ovr_state_nxt = ovr_state_r;
      unique case (ovr_state_r)
         OVR_IDLE: begin
            // New overrun edge starts the wait for a full byte
            if (set_overrun) begin
               ovr_state_nxt = OVR_WAIT_BYTE; // R5
            end
         end
         OVR_WAIT_BYTE: begin
            // Sync clears the flag, so the tracking ends too
            if (i_sync_pulse && !set_overrun) begin
               ovr_state_nxt = OVR_IDLE;
            end else if (i_byte_received) begin
               ovr_state_nxt = OVR_FORCE; // R6
            end
         end
         OVR_FORCE: begin
            // Another edge restarts the hold-off
            if (set_overrun) begin
               ovr_state_nxt = OVR_WAIT_BYTE;
            end else if (i_sync_pulse) begin
               ovr_state_nxt = OVR_IDLE; // R11
            end
         end
         default: begin
            // Illegal one-hot code recovers to idle
            ovr_state_nxt = OVR_IDLE;
         end
      endcase
   end

   // Status register update
   always_ff @(posedge i_sys_clk) begin
      if (i_srst) begin
         status_r <= `DSL_RESET_VALUE;
      end else begin
         status_r <= status_nxt;
      end
   end

   // Wait/stop bookkeeping and overrun state
   always_ff @(posedge i_sys_clk) begin
      if (i_srst) begin
         ws_prev_r <= 1'b0;
         ws_pend_r <= 1'b0;
         ovr_state_r <= OVR_IDLE;
      end else begin
         ws_prev_r <= ws_now;
         ws_pend_r <= ws_pend_nxt;
         ovr_state_r <= ovr_state_nxt;
      end
   end

   // Ack outputs registered; length held until the next ack
   always_ff @(posedge i_sys_clk) begin
      if (i_srst) begin
         o_ack_strobe <= 1'b0;
         o_ack_long <= 1'b0;
      end else begin
         o_ack_strobe <= ack_issue;
         // Length only changes with an ack so the pulse generator sees it stable
         if (ack_issue) begin
            o_ack_long <= long_nxt;
         end
      end
   end

   // Readback for the debug read command comes from the flop itself
   assign o_status_low = status_r;

endmodule

`default_nettype wire

// file: rtl/debug_status_defines.svh
`ifndef DEBUG_STATUS_DEFINES_SVH
`define DEBUG_STATUS_DEFINES_SVH

// Width of the debug status low register
`define DSL_WIDTH 8

// Field positions inside the debug status low register
`define DSL_WAIT_BIT 7
`define DSL_STOP_BIT 6
`define DSL_RAM_FAULT_BIT 5
`define DSL_OVERRUN_BIT 4
`define DSL_NO_RESPONSE_BIT 3
`define DSL_ILLEGAL_ACCESS_BIT 2
`define DSL_ILLEGAL_COMMAND_BIT 1
`define DSL_COMMAND_ERROR_BIT 0

// Value after reset: every flag clear
`define DSL_RESET_VALUE 8'h00

// Synchroniser depth for the debug pin
`define DSL_SYNC_STAGES 2

`endif

// file: rtl/debug_status_pkg.sv
package debug_status_pkg;

   // Overrun tracking, one-hot
   typedef enum logic [2:0] {
      OVR_IDLE = 3'b001,
      OVR_WAIT_BYTE = 3'b010,
      OVR_FORCE = 3'b100
   } overrun_state_t;

endpackage

// file: test/debug_host_model.sv
`timescale 1ns/10ps
`default_nettype none
// Far side of the debug wire: pulls the pin low for a set time
module debug_host_model (
   input wire logic i_sys_clk,
   input wire logic i_start,
   input wire logic [3:0] i_low_cycles,
   output logic o_debug_pin
);
   logic [3:0] low_r = 4'h0; // Cycles left with the wire held low
   // Released wire sits on its pull-up
   assign o_debug_pin = (low_r == 4'h0);
   // Start of a host transmission drops the wire
   always_ff @(posedge i_sys_clk) begin
      if (i_start) begin
         low_r <= i_low_cycles;
      end else if (low_r != 4'h0) begin
         low_r <= low_r - 4'h1;
      end
   end
endmodule
`default_nettype wire

// file: test/debug_status_ack_logic_sva.sv
`include "debug_status_defines.svh"
`timescale 1ns/10ps
`default_nettype none
// Ack length and status flag checks at the block ports
module debug_status_ack_logic_sva (
   input wire logic i_sys_clk,
   input wire logic i_srst,
   input wire logic i_ack_enable,
   input wire logic i_cmd_done,
   input wire logic i_cmd_uses_ack,
   input wire logic i_cmd_ok,
   input wire logic i_cmd_unimplemented,
   input wire logic i_cmd_illegal_other,
   input wire logic i_no_response,
   input wire logic i_illegal_access,
   input wire logic i_ack_pending,
   input wire logic i_sync_pulse,
   input wire logic [`DSL_WIDTH-1:0] o_status_low,
   input wire logic o_ack_strobe,
   input wire logic o_ack_long
);
   default clocking @(posedge i_sys_clk); endclocking
   default disable iff (i_srst);
   // Acked command; calm means no overrun hold-off can apply
   wire logic qual = i_cmd_done & i_cmd_uses_ack & i_ack_enable;
   wire logic calm = qual & ~i_ack_pending & ~o_status_low[4];
   wire logic cause = i_no_response | i_illegal_access | i_cmd_illegal_other;
   property p_ack; qual |=> o_ack_strobe; endproperty
   a_ack: assert property (p_ack) else $error("ack missing");
   property p_nack; !qual |=> !o_ack_strobe; endproperty
   a_nack: assert property (p_nack) else $error("stray ack");
   property p_flag; calm && cause |=> o_ack_long; endproperty
   a_flag: assert property (p_flag) else $error("flag ack not long");
   property p_fail; calm && !i_cmd_ok && !i_cmd_unimplemented |=> o_ack_long; endproperty
   a_fail: assert property (p_fail) else $error("failed ack not long");
   property p_norm;
      calm && !cause && i_cmd_ok && o_status_low[7:6] == 2'h0 && $stable(o_status_low[7:6]) |=> !o_ack_long;
   endproperty
   a_norm: assert property (p_norm) else $error("good ack not normal");
   property p_hold; !o_ack_strobe |-> $stable(o_ack_long); endproperty
   a_hold: assert property (p_hold) else $error("ack length moved");
   property p_set; i_no_response |=> o_status_low[3]; endproperty
   a_set: assert property (p_set) else $error("no response flag");
   property p_ovr; o_status_low[4] && !i_sync_pulse |=> o_status_low[4]; endproperty
   a_ovr: assert property (p_ovr) else $error("overrun lost");
   c_long: cover property (o_ack_strobe && o_ack_long);
   c_norm: cover property (o_ack_strobe && !o_ack_long);
   c_ovr: cover property ($rose(o_status_low[4]));
endmodule
bind debug_status_ack_logic debug_status_ack_logic_sva debug_status_ack_logic_sva_i (
   .i_sys_clk, .i_srst, .i_ack_enable, .i_cmd_done, .i_cmd_uses_ack, .i_cmd_ok, .i_cmd_unimplemented,
   .i_cmd_illegal_other, .i_no_response, .i_illegal_access, .i_ack_pending, .i_sync_pulse, .o_status_low,
   .o_ack_strobe, .o_ack_long
);
`default_nettype wire

// file: test/debug_status_ack_logic_tb.sv
`include "debug_status_defines.svh"
`timescale 1ns/10ps
`default_nettype none
module debug_status_ack_logic_tb;
   // Inputs quiet at time zero except ack enable and ack-type command, both high; reset high
   logic i_sys_clk = 1'h0, i_srst = 1'h1, i_bdc_enable = 1'h0, i_ack_enable = 1'h1, i_wait_mode = 1'h0;
   logic i_stop_mode = 1'h0, i_stop_request = 1'h0, i_ram_dbl_fault = 1'h0, i_ack_pending = 1'h0;
   logic i_byte_received = 1'h0, i_sync_pulse = 1'h0, i_cmd_done = 1'h0, i_cmd_uses_ack = 1'h1;
   logic i_cmd_ok = 1'h0, i_cmd_unimplemented = 1'h0, i_cmd_illegal_other = 1'h0, i_no_response = 1'h0;
   logic i_illegal_access = 1'h0, i_cmd_error = 1'h0, i_status_wr = 1'h0, host_go = 1'h0;
   logic [`DSL_WIDTH-1:0] i_status_wdata = 8'h00;
   logic [`DSL_WIDTH-1:0] o_status_low;
   logic i_debug_pin, o_ack_strobe, o_ack_long;
   int num_errors = 0, comparisons = 0;
   always #4 i_sys_clk = ~i_sys_clk;
   debug_status_ack_logic debug_status_ack_logic_i (
      .i_sys_clk, .i_srst, .i_debug_pin, .i_bdc_enable, .i_ack_enable, .i_wait_mode, .i_stop_mode,
      .i_stop_request, .i_ram_dbl_fault, .i_ack_pending, .i_byte_received, .i_sync_pulse, .i_cmd_done,
      .i_cmd_uses_ack, .i_cmd_ok, .i_cmd_unimplemented, .i_cmd_illegal_other, .i_no_response,
      .i_illegal_access, .i_cmd_error, .i_status_wr, .i_status_wdata, .o_status_low, .o_ack_strobe, .o_ack_long
   );
   debug_host_model debug_host_model_i (.i_sys_clk, .i_start(host_go), .i_low_cycles(4'h6), .o_debug_pin(i_debug_pin));
   // Inputs move 1 ns after the edge
   task automatic step();
      @(posedge i_sys_clk);
      #1;
   endtask
   task automatic cmp(input string n, input logic [7:0] e, input logic [7:0] g);
      comparisons++;
      if (g !== e) begin
         num_errors++;
         $display("CHECK FAILED %s expected %h seen %h", n, e, g);
      end
   endtask
   task automatic end_sim();
      $display("errors %0d comparisons %0d", num_errors, comparisons);
      if (num_errors == 0 && comparisons > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
   endtask
   // One finished command; the ack shows one edge later
   task automatic cmd(input logic ok, input logic un, input logic [2:0] c, input logic lng);
      i_cmd_done = 1'h1;
      {i_cmd_ok, i_cmd_unimplemented, i_no_response, i_illegal_access, i_cmd_illegal_other} = {ok, un, c};
      step();
      cmp("ack_strobe", {7'h00, i_ack_enable & i_cmd_uses_ack}, {7'h00, o_ack_strobe});
      if (i_ack_enable && i_cmd_uses_ack) cmp("ack_long", {7'h00, lng}, {7'h00, o_ack_long});
      {i_cmd_done, i_cmd_unimplemented, i_no_response, i_illegal_access, i_cmd_illegal_other} = 5'h00;
      step();
   endtask
   // Ones-to-clear write through the debug strobe, then read back
   task automatic wr(input logic [7:0] d, input logic [7:0] e);
      i_status_wr = 1'h1;
      i_status_wdata = d;
      step();
      i_status_wr = 1'h0;
      step();
      cmp("status_low", e, o_status_low);
   endtask
   initial begin
      repeat (5) step();
      i_srst = 1'h0;
      cmp("status_low", 8'h00, o_status_low);
      cmd(1'h0, 1'h0, 3'h0, 1'h1);
      for (int i = 0; i < 3; i++) begin
         cmd(1'h1, 1'h0, 3'h1 << i, 1'h1);
         cmd(1'h1, 1'h0, 3'h0, 1'h0);
         wr(8'h00, 8'h02 << i);
         wr(8'h02 << i, 8'h00);
      end
      cmd(1'h0, 1'h1, 3'h0, 1'h0);
      i_cmd_error = 1'h1;
      i_ram_dbl_fault = 1'h1;
      step();
      cmp("status_low", 8'h23, o_status_low);
      i_cmd_error = 1'h0;
      i_ram_dbl_fault = 1'h0;
      wr(8'h03, 8'h20);
      wr(8'h20, 8'h00);
      i_wait_mode = 1'h1;
      wr(8'h80, 8'h80);
      cmd(1'h1, 1'h0, 3'h0, 1'h1);
      cmd(1'h1, 1'h0, 3'h0, 1'h0);
      i_wait_mode = 1'h0;
      wr(8'h80, 8'h00);
      for (int i = 0; i < 2; i++) begin
         i_stop_request = 1'h1;
         step();
         i_stop_request = 1'h0;
         cmp("status_low", {1'h0, i_bdc_enable, 6'h00}, o_status_low);
         i_bdc_enable = 1'h1;
         i_stop_mode = 1'h1;
         step();
      end
      wr(8'h40, 8'h40);
      cmd(1'h1, 1'h0, 3'h0, 1'h1);
      i_stop_mode = 1'h0;
      wr(8'h40, 8'h00);
      i_ack_enable = 1'h0;
      cmd(1'h0, 1'h0, 3'h0, 1'h1);
      i_ack_enable = 1'h1;
      // Command without ack gets no strobe even with handshaking on
      i_cmd_uses_ack = 1'h0;
      cmd(1'h0, 1'h0, 3'h0, 1'h1);
      i_cmd_uses_ack = 1'h1;
      i_ack_pending = 1'h1;
      host_go = 1'h1;
      step();
      host_go = 1'h0;
      for (int k = 0; k < 8 && o_status_low[4] !== 1'h1; k++) step();
      cmp("status_low", 8'h10, o_status_low);
      cmd(1'h0, 1'h0, 3'h0, 1'h0);
      i_ack_pending = 1'h0;
      i_byte_received = 1'h1;
      step();
      i_byte_received = 1'h0;
      cmd(1'h1, 1'h0, 3'h0, 1'h1);
      wr(8'h10, 8'h10);
      i_sync_pulse = 1'h1;
      step();
      i_sync_pulse = 1'h0;
      cmp("status_low", 8'h00, o_status_low);
      cmd(1'h1, 1'h0, 3'h0, 1'h0);
      end_sim();
   end
endmodule
`default_nettype wire
